// [hw/rtcsb_bank.sv]
// always-on clock register bank: switch-off log, watch time, alarm, backup control
//
// Behaviour
// - read-only cause byte logs thermal, battery, clock, watchdog, battery-ok, software switch-offs.
// - bit 6 set when the first power key is held over ten seconds.
// - registers take reset values only at clock-domain power-on reset.
// - charge meter enable bit, forced off in power-off mode.
// - write-transfer bit loads watch time into running clock, then self-clears.
// - read-transfer bit snapshots running clock into watch time, then self-clears.
// - seconds watch time is 16 bits over two read-write bytes.
// - minutes watch time is 24 bits over three bytes, low first.
// - alarm minutes is 24 bits over three bytes, low first.
// - control bit 2 enables the alarm.
// - control bit 3 marks a backup battery present; control resets to 08.
// - control bit 4 enables backup charger, bit 5 keeps it on in off mode.
// - control bit 0 set by software, cleared when the clock supply fails.
// - backup charge bits 3:2 select current; byte resets to 04.
// - backup charge bits 1:0 select charge voltage.
// - force bit supplies the clock block from the backup battery.
// - signed drift trim applied to the running clock every minute.
// - status byte shows crystal running and selected slow clock source.
`timescale 1ns/100ps
module rtcsb_bank import rtcsb_pkg::*;
#(
	parameter longint KEY_LONG_CYC = KEY_LONG_CYC_DEF,
	parameter int TICKS_PER_SEC = SLOW_HZ
)
(
	// clock and clock-domain power-on reset
	input wire logic clk,
	input wire logic srst,
	// register port
	input wire rtcsb_reg_req_t reg_req,
	output logic [7:0] rdata,
	output logic rvalid,
	// switch-off events and power mode from the power controller
	input wire rtcsb_off_evt_t off_evt,
	input wire logic power_off_mode,
	// pins
	input wire logic slow_clk_in,
	input wire logic first_power_key,
	input wire logic clock_supply_fail,
	input wire logic crystal_running_flag,
	input wire logic [1:0] slow_clock_source_status,
	// controls out
	output logic charge_meter_enable,
	output logic backup_charger_enable,
	output logic backup_charge_in_off,
	output logic backup_battery_present,
	output logic [1:0] backup_current_select,
	output logic [1:0] backup_voltage_select,
	output logic backup_supply_force_bit,
	// events out
	output logic alarm_event
);

	localparam int KEY_W = $clog2(KEY_LONG_CYC + 1);

	if (KEY_LONG_CYC < 1 || KEY_LONG_CYC > 64'h0000_0000_FFFF_FFFF)
		$error("KEY_LONG_CYC out of range");

	logic [PIN_N-1:0] pin_meta_q;
	logic [PIN_N-1:0] pin_sync_q;
	logic slow_prev_q;
	logic slow_tick;
	logic sec_pulse;
	logic min_pulse;

	logic [7:0] cause_q;
	logic [7:0] cconf_q;
	logic [1:0] xfer_q;
	logic [15:0] watch_sec_q;
	logic [23:0] watch_min_q;
	logic [23:0] alarm_min_q;
	logic [7:0] ctrl_q;
	logic [7:0] bupchg_q;
	logic [7:0] force_q;
	logic [7:0] trim_q;
	logic [7:0] status_q;
	logic [15:0] run_sec_q;
	logic [23:0] run_min_q;
	logic [KEY_W-1:0] key_cnt_q;
	logic match_q;
	logic [7:0] rdata_d;
	logic alarm_match;

	// two-stage pin synchronisers
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			pin_meta_q <= '0;
			pin_sync_q <= '0;
		end
		else
		begin
			pin_meta_q <= {slow_clock_source_status, crystal_running_flag,
				clock_supply_fail, first_power_key, slow_clk_in};
			pin_sync_q <= pin_meta_q;
		end
	end

	// one tick per rising edge of the slow clock
	always_ff @(posedge clk)
	begin
		if (srst)
			slow_prev_q <= 1'b0;
		else
			slow_prev_q <= pin_sync_q[PIN_SLOW];
	end

	assign slow_tick = pin_sync_q[PIN_SLOW] && !slow_prev_q;

	rtcsb_tick #(.TICKS_PER_SEC(TICKS_PER_SEC)) u_tick
	(
		.clk(clk),
		.srst(srst),
		.slow_tick(slow_tick),
		.drift_trim_value(trim_q),
		.sec_pulse(sec_pulse),
		.min_pulse(min_pulse)
	);

	// software-written configuration; only the clock-domain reset clears it
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			cconf_q <= RST_ZERO;
			bupchg_q <= RST_BUPCHG;
			force_q <= RST_ZERO;
			trim_q <= RST_ZERO;
			alarm_min_q <= '0;
		end
		else if (reg_req.wr)
		begin
			unique case (reg_req.addr)
				OFS_CCONF: cconf_q <= reg_req.wdata & MASK_CCONF;
				OFS_BUPCHG: bupchg_q <= reg_req.wdata & MASK_BUPCHG;
				OFS_FORCE: force_q <= reg_req.wdata & MASK_FORCE;
				OFS_TRIM: trim_q <= reg_req.wdata;
				OFS_AMIN_LO: alarm_min_q[7:0] <= reg_req.wdata;
				OFS_AMIN_MID: alarm_min_q[15:8] <= reg_req.wdata;
				OFS_AMIN_HI: alarm_min_q[23:16] <= reg_req.wdata;
				default:
				begin
				end
			endcase
		end
	end

	// control byte; a failing clock supply drops the time-valid bit
	always_ff @(posedge clk)
	begin
		if (srst)
			ctrl_q <= RST_CTRL;
		else
		begin
			if (reg_req.wr && reg_req.addr == OFS_CTRL)
				ctrl_q <= reg_req.wdata & MASK_CTRL;
			if (pin_sync_q[PIN_SUPFAIL])
				ctrl_q[CTRL_VALID] <= 1'b0;
		end
	end

	// transfer requests; a new request in the serving cycle is kept
	always_ff @(posedge clk)
	begin
		if (srst)
			xfer_q <= 2'h0;
		else if (reg_req.wr && reg_req.addr == OFS_XFER)
			xfer_q <= reg_req.wdata[1:0] & MASK_XFER[1:0];
		else
			xfer_q <= 2'h0;
	end

	// watch-time buffers; a snapshot overrides a software byte write
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			watch_sec_q <= '0;
			watch_min_q <= '0;
		end
		else if (xfer_q[XFER_RD])
		begin
			watch_sec_q <= run_sec_q;
			watch_min_q <= run_min_q;
		end
		else if (reg_req.wr)
		begin
			unique case (reg_req.addr)
				OFS_WSEC_LO: watch_sec_q[7:0] <= reg_req.wdata;
				OFS_WSEC_HI: watch_sec_q[15:8] <= reg_req.wdata;
				OFS_WMIN_LO: watch_min_q[7:0] <= reg_req.wdata;
				OFS_WMIN_MID: watch_min_q[15:8] <= reg_req.wdata;
				OFS_WMIN_HI: watch_min_q[23:16] <= reg_req.wdata;
				default:
				begin
				end
			endcase
		end
	end

	// running clock
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			run_sec_q <= '0;
			run_min_q <= '0;
		end
		else if (xfer_q[XFER_WR])
		begin
			run_sec_q <= watch_sec_q;
			run_min_q <= watch_min_q;
		end
		else if (sec_pulse)
		begin
			run_sec_q <= run_sec_q + 16'h0001;
			if (min_pulse)
				run_min_q <= run_min_q + 24'h000001;
		end
	end

	// long press of the first power key
	always_ff @(posedge clk)
	begin
		if (srst)
			key_cnt_q <= '0;
		else if (!pin_sync_q[PIN_KEY])
			key_cnt_q <= '0;
		else if (key_cnt_q != KEY_W'(KEY_LONG_CYC))
			key_cnt_q <= key_cnt_q + 1'b1;
	end

	// sticky switch-off log
	always_ff @(posedge clk)
	begin
		if (srst)
			cause_q <= RST_ZERO;
		else
		begin
			cause_q[7] <= cause_q[7] | off_evt.host_thermal;
			cause_q[5] <= cause_q[5] | off_evt.battery_por;
			cause_q[4] <= cause_q[4] | off_evt.slow_clock_loss;
			cause_q[3] <= cause_q[3] | off_evt.watchdog;
			cause_q[2] <= cause_q[2] | off_evt.battery_ok;
			cause_q[1] <= cause_q[1] | off_evt.thermal;
			cause_q[0] <= cause_q[0] | off_evt.software;
			if (key_cnt_q == KEY_W'(KEY_LONG_CYC))
				cause_q[CAUSE_KEY_LONG] <= 1'b1;
		end
	end

	// slow clock status sampled from the pins
	always_ff @(posedge clk)
	begin
		if (srst)
			status_q <= RST_STATUS;
		else
		begin
			status_q <= RST_ZERO;
			status_q[STAT_XTAL_OK] <= pin_sync_q[PIN_XTAL];
			status_q[STAT_SRC_LO +: 2] <= pin_sync_q[PIN_SRC_LO +: 2];
		end
	end

	// alarm: one pulse on entering a match
	assign alarm_match = ctrl_q[CTRL_ALARM_EN] && run_min_q == alarm_min_q;

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			match_q <= 1'b0;
			alarm_event <= 1'b0;
		end
		else
		begin
			match_q <= alarm_match;
			alarm_event <= alarm_match && !match_q;
		end
	end

	// read data
	always_comb
	begin
		unique case (reg_req.addr)
			OFS_CAUSE: rdata_d = cause_q;
			OFS_CCONF: rdata_d = cconf_q;
			OFS_XFER: rdata_d = {6'h00, xfer_q};
			OFS_WSEC_LO: rdata_d = watch_sec_q[7:0];
			OFS_WSEC_HI: rdata_d = watch_sec_q[15:8];
			OFS_WMIN_LO: rdata_d = watch_min_q[7:0];
			OFS_WMIN_MID: rdata_d = watch_min_q[15:8];
			OFS_WMIN_HI: rdata_d = watch_min_q[23:16];
			OFS_AMIN_LO: rdata_d = alarm_min_q[7:0];
			OFS_AMIN_MID: rdata_d = alarm_min_q[15:8];
			OFS_AMIN_HI: rdata_d = alarm_min_q[23:16];
			OFS_CTRL: rdata_d = ctrl_q;
			OFS_BUPCHG: rdata_d = bupchg_q;
			OFS_FORCE: rdata_d = force_q;
			OFS_TRIM: rdata_d = trim_q;
			OFS_STATUS: rdata_d = status_q;
			default: rdata_d = RST_ZERO;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			rdata <= RST_ZERO;
			rvalid <= 1'b0;
		end
		else
		begin
			rvalid <= reg_req.rd;
			if (reg_req.rd)
				rdata <= rdata_d;
		end
	end

	// registered control outputs
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			charge_meter_enable <= 1'b0;
			backup_charger_enable <= 1'b0;
			backup_charge_in_off <= 1'b0;
			backup_battery_present <= 1'b0;
			backup_current_select <= 2'h0;
			backup_voltage_select <= 2'h0;
			backup_supply_force_bit <= 1'b0;
		end
		else
		begin
			charge_meter_enable <= cconf_q[CCONF_EN] && !power_off_mode;
			backup_charger_enable <= ctrl_q[CTRL_CHG_EN];
			backup_charge_in_off <= ctrl_q[CTRL_CHG_EN] && ctrl_q[CTRL_CHG_OFF];
			backup_battery_present <= ctrl_q[CTRL_PRESENT];
			backup_current_select <= bupchg_q[BUP_ICH_LO +: 2];
			backup_voltage_select <= bupchg_q[BUP_VCH_LO +: 2];
			backup_supply_force_bit <= force_q[FORCE_BIT];
		end
	end

endmodule

// [hw/rtcsb_pkg.sv]
// constants and carrier types of the always-on clock register bank
package rtcsb_pkg;

	// register offsets
	localparam logic [15:0] OFS_CAUSE = 16'h0F00;
	localparam logic [15:0] OFS_CCONF = 16'h0F01;
	localparam logic [15:0] OFS_XFER = 16'h0F02;
	localparam logic [15:0] OFS_WSEC_LO = 16'h0F03;
	localparam logic [15:0] OFS_WSEC_HI = 16'h0F04;
	localparam logic [15:0] OFS_WMIN_LO = 16'h0F05;
	localparam logic [15:0] OFS_WMIN_MID = 16'h0F06;
	localparam logic [15:0] OFS_WMIN_HI = 16'h0F07;
	localparam logic [15:0] OFS_AMIN_LO = 16'h0F08;
	localparam logic [15:0] OFS_AMIN_MID = 16'h0F09;
	localparam logic [15:0] OFS_AMIN_HI = 16'h0F0A;
	localparam logic [15:0] OFS_CTRL = 16'h0F0B;
	localparam logic [15:0] OFS_BUPCHG = 16'h0F0C;
	localparam logic [15:0] OFS_FORCE = 16'h0F0D;
	localparam logic [15:0] OFS_TRIM = 16'h0F0E;
	localparam logic [15:0] OFS_STATUS = 16'h0F0F;

	// first power-on values
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] RST_CTRL = 8'h08;
	localparam logic [7:0] RST_BUPCHG = 8'h04;
	localparam logic [7:0] RST_STATUS = 8'h04;

	// writable bits per register
	localparam logic [7:0] MASK_CCONF = 8'h01;
	localparam logic [7:0] MASK_XFER = 8'h03;
	localparam logic [7:0] MASK_CTRL = 8'h3D;
	localparam logic [7:0] MASK_BUPCHG = 8'h0F;
	localparam logic [7:0] MASK_FORCE = 8'h01;

	// field positions
	localparam int CAUSE_KEY_LONG = 6;
	localparam int CCONF_EN = 0;
	localparam int XFER_WR = 1;
	localparam int XFER_RD = 0;
	localparam int CTRL_VALID = 0;
	localparam int CTRL_ALARM_EN = 2;
	localparam int CTRL_PRESENT = 3;
	localparam int CTRL_CHG_EN = 4;
	localparam int CTRL_CHG_OFF = 5;
	localparam int BUP_ICH_LO = 2;
	localparam int BUP_VCH_LO = 0;
	localparam int FORCE_BIT = 0;
	localparam int TRIM_SIGN = 7;
	localparam int STAT_XTAL_OK = 2;
	localparam int STAT_SRC_LO = 0;

	// timing
	localparam int SLOW_HZ = 32768;
	localparam int SEC_PER_MIN = 60;
	localparam int KEY_LONG_S = 10;
	localparam longint CLK_HZ = 100000000;
	localparam longint KEY_LONG_CYC_DEF = longint'(KEY_LONG_S) * CLK_HZ;

	// pin vector layout
	localparam int PIN_SLOW = 0;
	localparam int PIN_KEY = 1;
	localparam int PIN_SUPFAIL = 2;
	localparam int PIN_XTAL = 3;
	localparam int PIN_SRC_LO = 4;
	localparam int PIN_N = 6;

	typedef struct packed {
		logic host_thermal;
		logic battery_por;
		logic slow_clock_loss;
		logic watchdog;
		logic battery_ok;
		logic thermal;
		logic software;
	} rtcsb_off_evt_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [15:0] addr;
		logic [7:0] wdata;
	} rtcsb_reg_req_t;

endpackage

// [hw/rtcsb_tick.sv]
// seconds and minute pulses from slow-clock ticks, with per-minute drift trim
`timescale 1ns/100ps
module rtcsb_tick import rtcsb_pkg::*;
#(
	parameter int TICKS_PER_SEC = SLOW_HZ
)
(
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// tick in and trim
	input wire logic slow_tick,
	input wire logic [7:0] drift_trim_value,
	// pulses out
	output logic sec_pulse,
	output logic min_pulse
);

	localparam int PRESC_W = $clog2(TICKS_PER_SEC);
	localparam logic [PRESC_W-1:0] PRESC_LAST = PRESC_W'(TICKS_PER_SEC - 1);

	// the largest trim magnitude must still fit inside one second
	if (TICKS_PER_SEC < 128 || TICKS_PER_SEC > 1048576)
		$error("TICKS_PER_SEC out of range");
	localparam logic [5:0] SEC_LAST = 6'(SEC_PER_MIN - 1);

	logic [PRESC_W-1:0] presc_q;
	logic [6:0] stall_q;
	logic [5:0] secs_q;
	logic wrap;
	logic min_wrap;

	assign wrap = slow_tick && stall_q == 7'h00 && presc_q == PRESC_LAST;
	assign min_wrap = wrap && secs_q == SEC_LAST;

	// prescaler; at each minute a negative trim skips ticks, a positive one swallows them
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			presc_q <= '0;
			stall_q <= 7'h00;
		end
		else if (slow_tick)
		begin
			if (stall_q != 7'h00)
				stall_q <= stall_q - 7'h01;
			else if (min_wrap && drift_trim_value[TRIM_SIGN])
				presc_q <= PRESC_W'(drift_trim_value[6:0]);
			else if (min_wrap)
			begin
				presc_q <= '0;
				stall_q <= drift_trim_value[6:0];
			end
			else
				presc_q <= presc_q + 1'b1;
		end
	end

	// seconds within the minute
	always_ff @(posedge clk)
	begin
		if (srst)
			secs_q <= 6'h00;
		else if (min_wrap)
			secs_q <= 6'h00;
		else if (wrap)
			secs_q <= secs_q + 6'h01;
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			sec_pulse <= 1'b0;
			min_pulse <= 1'b0;
		end
		else
		begin
			sec_pulse <= wrap;
			min_pulse <= min_wrap;
		end
	end

endmodule

// [dv/rtcsb_bank_assertions.sv]
// port checker for the clock register bank
`timescale 1ns/100ps
module rtcsb_bank_assertions import rtcsb_pkg::*;
#(
	parameter longint KEY_LONG_CYC = KEY_LONG_CYC_DEF
)
(
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// register port
	input wire rtcsb_reg_req_t reg_req,
	input wire logic [7:0] rdata,
	input wire logic rvalid,
	// events and pins
	input wire rtcsb_off_evt_t off_evt,
	input wire logic power_off_mode,
	input wire logic slow_clk_in,
	input wire logic first_power_key,
	input wire logic clock_supply_fail,
	input wire logic crystal_running_flag,
	input wire logic [1:0] slow_clock_source_status,
	// controls and events
	input wire logic charge_meter_enable,
	input wire logic backup_charger_enable,
	input wire logic backup_charge_in_off,
	input wire logic backup_battery_present,
	input wire logic [1:0] backup_current_select,
	input wire logic [1:0] backup_voltage_select,
	input wire logic backup_supply_force_bit,
	input wire logic alarm_event
);
	logic [1:0] settle_q;

	// cycles since reset release, saturating
	always_ff @(posedge clk)
	begin
		if (srst)
			settle_q <= 2'h0;
		else if (settle_q != 2'h3)
			settle_q <= settle_q + 2'h1;
	end

	default clocking @(posedge clk);
	endclocking
	default disable iff (srst);

	a_read_answer: assert property (reg_req.rd |=> rvalid)
		else $error("read got no answer");
	a_no_stray_answer: assert property (!reg_req.rd |=> !rvalid)
		else $error("answer without read");
	a_meter_forced_off: assert property (power_off_mode |=> !charge_meter_enable)
		else $error("charge meter on in power-off mode");
	a_charge_in_off: assert property (backup_charge_in_off |-> backup_charger_enable)
		else $error("off-mode charge without charger enable");
	a_status_reserved: assert property (reg_req.rd && reg_req.addr == OFS_STATUS |=> rdata[7:3] == 5'h00)
		else $error("status reserved bits set");
	a_ctrl_reserved: assert property (reg_req.rd && reg_req.addr == OFS_CTRL |=> !rdata[7] && !rdata[6] && !rdata[1])
		else $error("control reserved bits set");
	a_charge_reserved: assert property (reg_req.rd && reg_req.addr == OFS_BUPCHG |=> rdata[7:4] == 4'h0)
		else $error("charge byte reserved bits set");
	a_single_bit: assert property (reg_req.rd && (reg_req.addr == OFS_CCONF || reg_req.addr == OFS_FORCE)
		|=> rdata[7:1] == 7'h00)
		else $error("single-bit register upper bits set");
	a_alarm_single: assert property (alarm_event |=> !alarm_event)
		else $error("alarm event longer than one cycle");
	a_controls_hold: assert property (settle_q == 2'h3 && !reg_req.wr ##1 !reg_req.wr
		|=> $stable(backup_current_select) && $stable(backup_voltage_select) && $stable(backup_supply_force_bit))
		else $error("control output moved without a write");

	c_alarm: cover property (alarm_event);
	c_status_read: cover property (reg_req.rd && reg_req.addr == OFS_STATUS);
	c_charge_off: cover property (backup_charge_in_off);
endmodule

bind rtcsb_bank rtcsb_bank_assertions #(.KEY_LONG_CYC(KEY_LONG_CYC)) u_chk (.clk, .srst, .reg_req, .rdata, .rvalid,
	.off_evt, .power_off_mode, .slow_clk_in, .first_power_key, .clock_supply_fail, .crystal_running_flag,
	.slow_clock_source_status, .charge_meter_enable, .backup_charger_enable, .backup_charge_in_off,
	.backup_battery_present, .backup_current_select, .backup_voltage_select, .backup_supply_force_bit, .alarm_event);

// [dv/test_rtc_switchoff_backup_bank.sv]
// self-checking bench of the clock register bank
`timescale 1ns/100ps
module test_rtc_switchoff_backup_bank import rtcsb_pkg::*;
();
	localparam int KEY_CYC = 50;
	localparam int TPS = 128;
	logic clk = 1'b0;
	logic srst = 1'b1;
	rtcsb_reg_req_t reg_req = '0;
	rtcsb_off_evt_t off_evt = '0;
	logic power_off_mode = 1'b0;
	logic slow_clk_in = 1'b0;
	logic first_power_key = 1'b0;
	logic clock_supply_fail = 1'b0;
	logic crystal_running_flag = 1'b1;
	logic [1:0] slow_clock_source_status = 2'h0;
	logic [7:0] rdata;
	logic rvalid, charge_meter_enable, backup_charger_enable, backup_charge_in_off, backup_battery_present;
	logic backup_supply_force_bit, alarm_event;
	logic [1:0] backup_current_select, backup_voltage_select;
	logic [7:0] model_q [16];
	int failures = 0;
	int checks_done = 0;
	int alarm_cnt = 0;
	logic [15:0] sec_m;
	logic [23:0] min_m;
	int presc_m, stall_m, secs_m;

	always #5 clk = ~clk;
	always @(posedge clk)
		if (alarm_event === 1'b1)
			alarm_cnt++;

	rtcsb_bank #(.KEY_LONG_CYC(longint'(KEY_CYC)), .TICKS_PER_SEC(TPS)) dut (.clk, .srst, .reg_req, .rdata, .rvalid,
		.off_evt,
		.power_off_mode, .slow_clk_in, .first_power_key, .clock_supply_fail, .crystal_running_flag,
		.slow_clock_source_status, .charge_meter_enable, .backup_charger_enable, .backup_charge_in_off,
		.backup_battery_present, .backup_current_select, .backup_voltage_select, .backup_supply_force_bit,
		.alarm_event);

	task automatic print_verdict();
		if (failures == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic check(input string name, input logic [7:0] exp, input logic [7:0] act);
		checks_done++;
		if (act !== exp)
		begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", name, exp, act);
		end
	endtask

	task automatic reg_write(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_req.wr <= 1'b1;
		reg_req.addr <= a;
		reg_req.wdata <= d;
		@(posedge clk);
		reg_req.wr <= 1'b0;
	endtask

	task automatic reg_read(input logic [15:0] a, output logic [7:0] d);
		int n;
		@(posedge clk);
		reg_req.rd <= 1'b1;
		reg_req.addr <= a;
		@(posedge clk);
		reg_req.rd <= 1'b0;
		n = 0;
		#1;
		while (rvalid !== 1'b1 && n < 4)
		begin
			@(posedge clk);
			#1;
			n++;
		end
		d = rdata;
		check("rvalid", 8'h01, {7'h00, rvalid});
		if (rvalid !== 1'b1)
			print_verdict();
	endtask

	task automatic rd_chk(input int i);
		logic [7:0] d;
		reg_read(16'h0F00 + 16'(i), d);
		check($sformatf("reg 0F%02h", i), model_q[i], d);
	endtask

	task automatic out_chk();
		repeat (3) @(posedge clk);
		check("meter", {7'h00, model_q[1][0] & ~power_off_mode}, {7'h00, charge_meter_enable});
		check("controls", {model_q[11][5] & model_q[11][4], model_q[11][4:3], model_q[12][3:0], model_q[13][0]},
			{backup_charge_in_off, backup_charger_enable, backup_battery_present, backup_current_select,
			backup_voltage_select, backup_supply_force_bit});
	endtask

	task automatic reset_model();
		model_q = '{default: 8'h00};
		model_q[11] = RST_CTRL;
		model_q[12] = RST_BUPCHG;
		model_q[15] = {5'h00, crystal_running_flag, slow_clock_source_status};
	endtask

	// slow clock pulses, one tick each, with the running-clock model
	task automatic slow_ticks(input int n);
		repeat (n)
		begin
			@(posedge clk);
			slow_clk_in <= 1'b1;
			@(posedge clk);
			slow_clk_in <= 1'b0;
			if (stall_m > 0)
				stall_m--;
			else if (presc_m < TPS - 1)
				presc_m++;
			else
			begin
				presc_m = 0;
				sec_m++;
				secs_m = (secs_m + 1) % SEC_PER_MIN;
				if (secs_m == 0)
				begin
					min_m++;
					if (model_q[14][TRIM_SIGN])
						presc_m = model_q[14][6:0];
					else
						stall_m = model_q[14][6:0];
				end
			end
		end
	endtask

	// snapshot the running clock and compare the watch bytes
	task automatic snap_chk();
		repeat (4) @(posedge clk);
		reg_write(OFS_XFER, 8'h01);
		{model_q[4], model_q[3]} = sec_m;
		{model_q[7], model_q[6], model_q[5]} = min_m;
		for (int i = 3; i < 8; i++)
			rd_chk(i);
	endtask

	function automatic logic [7:0] wmask(input int i);
		case (i)
			0, 2, 15: return 8'h00;
			1: return MASK_CCONF;
			11: return MASK_CTRL;
			12: return MASK_BUPCHG;
			13: return MASK_FORCE;
			default: return 8'hFF;
		endcase
	endfunction

	initial
	begin
		logic [7:0] v;
		void'($urandom(38747));
		reset_model();
		repeat (12) @(posedge clk);
		srst <= 1'b0;
		repeat (5) @(posedge clk);
		for (int i = 0; i < 16; i++)
			rd_chk(i);
		// random fill, read-only and unmapped writes dropped
		for (int i = 0; i < 16; i++)
		begin
			v = 8'($urandom());
			if (i != 2)
				reg_write(16'h0F00 + 16'(i), v);
			model_q[i] = model_q[i] & ~wmask(i) | v & wmask(i);
		end
		reg_write(16'h0E4B, 8'hFF);
		reg_write(16'h1010, 8'hFF);
		@(posedge clk);
		crystal_running_flag <= 1'($urandom());
		slow_clock_source_status <= 2'($urandom());
		repeat (5) @(posedge clk);
		model_q[15] = {5'h00, crystal_running_flag, slow_clock_source_status};
		for (int i = 0; i < 16; i++)
			rd_chk(i);
		reg_read(16'h0F10, v);
		check("unmapped", 8'h00, v);
		out_chk();
		reg_write(OFS_CCONF, 8'h01);
		model_q[1] = 8'h01;
		out_chk();
		power_off_mode <= 1'b1;
		out_chk();
		power_off_mode <= 1'b0;
		// switch-off cause log
		for (int i = 0; i < 7; i++)
		begin
			@(posedge clk);
			off_evt <= rtcsb_off_evt_t'(7'h01 << i);
			@(posedge clk);
			off_evt <= '0;
			model_q[0][(i == 6) ? 7 : i] = 1'b1;
			rd_chk(0);
		end
		first_power_key <= 1'b1;
		repeat (KEY_CYC - 10) @(posedge clk);
		first_power_key <= 1'b0;
		rd_chk(0);
		first_power_key <= 1'b1;
		repeat (KEY_CYC + 10) @(posedge clk);
		first_power_key <= 1'b0;
		model_q[0][CAUSE_KEY_LONG] = 1'b1;
		rd_chk(0);
		reg_write(OFS_CTRL, 8'h39);
		model_q[11] = 8'h39;
		out_chk();
		rd_chk(11);
		clock_supply_fail <= 1'b1;
		repeat (5) @(posedge clk);
		clock_supply_fail <= 1'b0;
		model_q[11][CTRL_VALID] = 1'b0;
		rd_chk(11);
		// load running clock, overwrite, snapshot back
		for (int i = 3; i < 8; i++)
		begin
			model_q[i] = 8'($urandom());
			reg_write(16'h0F00 + 16'(i), model_q[i]);
		end
		reg_write(OFS_XFER, 8'h02);
		rd_chk(2);
		for (int i = 3; i < 8; i++)
			reg_write(16'h0F00 + 16'(i), ~model_q[i]);
		reg_write(OFS_XFER, 8'h01);
		rd_chk(2);
		for (int i = 3; i < 8; i++)
			rd_chk(i);
		for (int i = 8; i < 11; i++)
		begin
			model_q[i] = model_q[i - 3];
			reg_write(16'h0F00 + 16'(i), model_q[i]);
		end
		#1 alarm_cnt = 0;
		model_q[11][CTRL_ALARM_EN] = 1'b1;
		reg_write(OFS_CTRL, model_q[11]);
		repeat (10) @(posedge clk);
		check("alarm count", 8'h01, 8'(alarm_cnt));
		// second power-on reset mid-run
		srst <= 1'b1;
		repeat (12) @(posedge clk);
		srst <= 1'b0;
		repeat (5) @(posedge clk);
		reset_model();
		for (int i = 0; i < 16; i++)
			rd_chk(i);
		out_chk();
		// running clock over two trimmed minutes, alarm on the first minute carry
		presc_m = 0;
		stall_m = 0;
		secs_m = 0;
		sec_m = 16'($urandom());
		min_m = 24'($urandom());
		{model_q[4], model_q[3]} = sec_m;
		{model_q[7], model_q[6], model_q[5]} = min_m;
		{model_q[10], model_q[9], model_q[8]} = min_m + 24'h000001;
		for (int i = 3; i < 11; i++)
			reg_write(16'h0F00 + 16'(i), model_q[i]);
		reg_write(OFS_XFER, 8'h02);
		model_q[14] = 8'h85;
		reg_write(OFS_TRIM, model_q[14]);
		model_q[11] = 8'h0C;
		reg_write(OFS_CTRL, model_q[11]);
		#1 alarm_cnt = 0;
		slow_ticks(SEC_PER_MIN * TPS);
		snap_chk();
		check("alarm count", 8'h01, 8'(alarm_cnt));
		slow_ticks(TPS - 6);
		snap_chk();
		slow_ticks(1);
		snap_chk();
		model_q[14] = 8'h05;
		reg_write(OFS_TRIM, model_q[14]);
		slow_ticks((SEC_PER_MIN - 1) * TPS);
		snap_chk();
		slow_ticks(TPS + 4);
		snap_chk();
		slow_ticks(1);
		snap_chk();
		check("alarm count", 8'h01, 8'(alarm_cnt));
		print_verdict();
	end
endmodule
